//--- rtl/rfcd_regs.svh
// Constants of the vicinity-card command decoder
`ifndef RFCD_REGS_SVH
`define RFCD_REGS_SVH
`define RFCD_CMD_INVENTORY 8'h01
`define RFCD_CMD_QUIET 8'h02
`define RFCD_CMD_RD_SINGLE 8'h20
`define RFCD_CMD_WR_SINGLE 8'h21
`define RFCD_CMD_RD_MULTI 8'h23
`define RFCD_CMD_SELECT 8'h25
`define RFCD_CMD_RST_READY 8'h26
`define RFCD_CMD_RD_REGF 8'ha0
`define RFCD_CMD_WR_REGF 8'ha1
`define RFCD_CMD_RD_IDEV 8'ha2
`define RFCD_CMD_WR_IDEV 8'ha3
`define RFCD_CMD_RD_XMEM 8'ha4
`define RFCD_FLG_SELECT 4
`define RFCD_FLG_ADDR 5
`define RFCD_FLG_INV 2
`define RFCD_FLG_OPTION 6
`define RFCD_FLG_SEL_NI 4
`define RFCD_RSP_OK 8'h00
`define RFCD_RSP_ERR 8'h01
`define RFCD_ERR_UNSUPP 8'h01
`define RFCD_DSFID 8'h00
`define RFCD_CRC_INIT 16'hffff
`define RFCD_CRC_POLY 16'h8408
`define RFCD_CRC_RESIDUE 16'hf0b8
`define RFCD_MAKER_CODE 8'h5a // Arbitrary maker byte value
`endif

//--- rtl/rfcd_pkg.sv
// Types of the vicinity-card command decoder
package rfcd_pkg;
  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
  } rfcd_rx_t;
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } rfcd_tx_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rfcd_acc_t;
  typedef enum logic [1:0] {
    RFCD_READY = 2'b00,
    RFCD_QUIET = 2'b01,
    RFCD_SELECTED = 2'b10
  } rfcd_tag_t;
  typedef enum logic [6:0] {
    RFCD_ST_IDLE = 7'b0000001,
    RFCD_ST_RECV = 7'b0000010,
    RFCD_ST_ACC = 7'b0000100,
    RFCD_ST_WAIT = 7'b0001000,
    RFCD_ST_EOFW = 7'b0010000,
    RFCD_ST_SEND = 7'b0100000,
    RFCD_ST_CRC = 7'b1000000
  } rfcd_st_t;
endpackage : rfcd_pkg

//--- rtl/rfcd_crc16.sv
// Bytewise CRC-16 of the vicinity-card protocol, reflected form
`timescale 1ns/1ps
`include "rfcd_regs.svh"
module rfcd_crc16 (
  input wire logic [15:0] i_crc,
  input wire logic [7:0] i_data,
  output logic [15:0] o_crc
);
  // Eight reflected polynomial steps per byte
  always_comb begin
    logic [15:0] c;
    c = i_crc ^ {8'h00, i_data};
    for (int k = 0; k < 8; k++) begin
      c = c[0] ? ((c >> 1) ^ `RFCD_CRC_POLY) : (c >> 1);
    end
    o_crc = c;
  end
endmodule : rfcd_crc16

//--- rtl/rfcd_decoder.sv
// Command decoder and reply framer of the vicinity-card transponder
`timescale 1ns/1ps
`include "rfcd_regs.svh"
module rfcd_decoder (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [63:0] i_uid,
  input wire rfcd_pkg::rfcd_rx_t i_rx,
  output rfcd_pkg::rfcd_tx_t o_tx,
  input wire logic i_tx_ready,
  output rfcd_pkg::rfcd_acc_t o_eep,
  output rfcd_pkg::rfcd_acc_t o_regf,
  output rfcd_pkg::rfcd_acc_t o_idev,
  output logic [7:0] o_idev_unit,
  output rfcd_pkg::rfcd_acc_t o_spi,
  input wire logic i_ack,
  input wire logic [15:0] i_rdata,
  output rfcd_pkg::rfcd_tag_t o_tag_state,
  output logic o_busy
);
  // All decoder state in one packed word
  typedef struct packed {
    rfcd_pkg::rfcd_st_t st;
    rfcd_pkg::rfcd_tag_t tag;
    logic [5:0] cnt;
    logic [7:0] flags;
    logic [7:0] cmd;
    logic [63:0] uidrx;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [7:0] nblk;
    logic [15:0] crc;
    logic [3:0] tlen;
    logic [3:0] tcnt;
    logic [79:0] tbuf;
    logic tmore;
    rfcd_pkg::rfcd_tx_t tx;
    rfcd_pkg::rfcd_acc_t acc;
    logic [1:0] tgt;
  } rfcd_s_t;

  rfcd_s_t s_ff;
  rfcd_s_t nxt_s;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic [7:0] tx_byte;

  // Bytes ahead of the parameters: flags, command, maker byte, addressed UID
  function automatic logic [5:0] rfcd_hdr(input logic [7:0] cmd, input logic [7:0] flags);
    logic [5:0] n;
    n = cmd[7] ? 6'd3 : 6'd2;
    if (flags[`RFCD_FLG_ADDR] && !flags[`RFCD_FLG_INV]) begin
      n = n + 6'd8;
    end
    return n;
  endfunction : rfcd_hdr

  // Running CRC over received bytes and transmitted bytes
  rfcd_crc16 u_crc_rx (.i_crc(s_ff.crc), .i_data(i_rx.data), .o_crc(rx_crc));
  rfcd_crc16 u_crc_tx (.i_crc(s_ff.crc), .i_data(tx_byte), .o_crc(tx_crc));
  assign tx_byte = s_ff.tbuf[79:72];

  // Frame reception, decode, access and reply sequencing
  always_comb begin
    logic addr_ok;
    logic is_custom;
    logic [5:0] pidx;
    addr_ok = 1'b0;
    is_custom = 1'b0;
    pidx = 6'd0;
    nxt_s = s_ff;
    nxt_s.tx.valid = 1'b0;
    nxt_s.tx.last = 1'b0;
    case (s_ff.st)
      rfcd_pkg::RFCD_ST_IDLE: begin
        if (i_rx.valid && i_rx.sof) begin
          nxt_s.st = rfcd_pkg::RFCD_ST_RECV;
          nxt_s.cnt = 6'd0;
          nxt_s.crc = `RFCD_CRC_INIT;
        end
      end
      rfcd_pkg::RFCD_ST_RECV: begin
        if (i_rx.valid && i_rx.eof) begin
          // Residue check drops corrupt frames with no reply
          nxt_s.st = rfcd_pkg::RFCD_ST_IDLE;
          nxt_s.crc = `RFCD_CRC_INIT; // Fresh CRC for the reply
          if (s_ff.crc == `RFCD_CRC_RESIDUE) begin
            addr_ok = !s_ff.flags[`RFCD_FLG_ADDR] || (s_ff.uidrx == i_uid);
            if (s_ff.tag == rfcd_pkg::RFCD_QUIET && !s_ff.flags[`RFCD_FLG_ADDR]) begin
              addr_ok = 1'b0;
            end
            if (s_ff.flags[`RFCD_FLG_SEL_NI] && !s_ff.flags[`RFCD_FLG_INV] &&
                s_ff.tag != rfcd_pkg::RFCD_SELECTED) begin
              addr_ok = 1'b0;
            end
            nxt_s.tbuf = {`RFCD_RSP_OK, 72'h0};
            nxt_s.tlen = 4'd1;
            nxt_s.tmore = 1'b0;
            if (s_ff.flags[`RFCD_FLG_INV] && s_ff.cmd == `RFCD_CMD_INVENTORY) begin
              // Anti-collision answer with UID
              if (s_ff.tag != rfcd_pkg::RFCD_QUIET) begin
                nxt_s.tbuf = {`RFCD_RSP_OK, `RFCD_DSFID, i_uid[7:0], i_uid[15:8],
                  i_uid[23:16], i_uid[31:24], i_uid[39:32], i_uid[47:40],
                  i_uid[55:48], i_uid[63:56]};
                nxt_s.tlen = 4'd10;
                nxt_s.st = rfcd_pkg::RFCD_ST_SEND;
              end
            end else if (s_ff.cmd == `RFCD_CMD_SELECT) begin
              // Own UID selects, foreign UID leaves state alone
              if (s_ff.uidrx == i_uid) begin
                nxt_s.tag = rfcd_pkg::RFCD_SELECTED;
                nxt_s.st = rfcd_pkg::RFCD_ST_SEND;
              end
            end else if (addr_ok) begin
              is_custom = 1'b1;
              nxt_s.acc.addr = s_ff.addr;
              nxt_s.acc.wdata = s_ff.wdata;
              nxt_s.acc.wr = 1'b0;
              case (s_ff.cmd)
                `RFCD_CMD_QUIET: begin
                  nxt_s.tag = rfcd_pkg::RFCD_QUIET;
                end
                `RFCD_CMD_RST_READY: begin
                  nxt_s.tag = rfcd_pkg::RFCD_READY;
                  nxt_s.st = rfcd_pkg::RFCD_ST_SEND;
                end
                `RFCD_CMD_RD_SINGLE, `RFCD_CMD_RD_MULTI: begin
                  nxt_s.tgt = 2'd0;
                  nxt_s.st = rfcd_pkg::RFCD_ST_ACC;
                end
                `RFCD_CMD_WR_SINGLE: begin
                  nxt_s.tgt = 2'd0;
                  nxt_s.acc.wr = 1'b1;
                  if (s_ff.flags[`RFCD_FLG_OPTION]) begin
                    nxt_s.st = rfcd_pkg::RFCD_ST_ACC;
                  end else begin
                    nxt_s.tbuf = {`RFCD_RSP_ERR, 8'h03, 64'h0};
                    nxt_s.tlen = 4'd2;
                    nxt_s.st = rfcd_pkg::RFCD_ST_SEND;
                  end
                end
                `RFCD_CMD_RD_REGF, `RFCD_CMD_WR_REGF: begin
                  nxt_s.tgt = 2'd1;
                  nxt_s.acc.wr = s_ff.cmd[0];
                  nxt_s.st = rfcd_pkg::RFCD_ST_ACC;
                end
                `RFCD_CMD_RD_IDEV, `RFCD_CMD_WR_IDEV: begin
                  nxt_s.tgt = 2'd2;
                  nxt_s.acc.wr = s_ff.cmd[0];
                  nxt_s.st = rfcd_pkg::RFCD_ST_ACC;
                end
                `RFCD_CMD_RD_XMEM: begin
                  nxt_s.tgt = 2'd3;
                  nxt_s.st = rfcd_pkg::RFCD_ST_ACC;
                end
                default: begin
                  nxt_s.tbuf = {`RFCD_RSP_ERR, `RFCD_ERR_UNSUPP, 64'h0};
                  nxt_s.tlen = 4'd2;
                  nxt_s.st = rfcd_pkg::RFCD_ST_SEND;
                end
              endcase
              nxt_s.acc.req = (nxt_s.st == rfcd_pkg::RFCD_ST_ACC) && is_custom;
            end
          end
        end else if (i_rx.valid) begin
          // Byte placement: flags, command, maker byte, UID, parameters
          nxt_s.crc = rx_crc;
          if (s_ff.cnt != 6'h3f) begin
            nxt_s.cnt = s_ff.cnt + 6'd1;
          end
          if (s_ff.cnt == 6'd0) begin
            nxt_s.flags = i_rx.data;
          end else if (s_ff.cnt == 6'd1) begin
            nxt_s.cmd = i_rx.data;
          end else if (s_ff.cmd[7] && s_ff.cnt == 6'd2) begin
            nxt_s.cnt = s_ff.cnt + 6'd1; // Maker byte skipped
          end else if (s_ff.cnt < rfcd_hdr(s_ff.cmd, s_ff.flags)) begin
            nxt_s.uidrx = {i_rx.data, s_ff.uidrx[63:8]}; // UID arrives low byte first
          end else begin
            // Parameters by position; trailing CRC bytes at positions 1 and 2 still load wdata and nblk
            pidx = s_ff.cnt - rfcd_hdr(s_ff.cmd, s_ff.flags);
            case (pidx)
              6'd0: nxt_s.addr = {8'h00, i_rx.data};
              6'd1: begin
                if (s_ff.cmd == `RFCD_CMD_RD_XMEM) begin
                  nxt_s.addr[15:8] = i_rx.data;
                end
                nxt_s.wdata[7:0] = i_rx.data;
                nxt_s.nblk = i_rx.data;
              end
              6'd2: nxt_s.wdata[15:8] = i_rx.data;
              default: ;
            endcase
          end
          if (s_ff.cnt == 6'd0) begin
            nxt_s.addr = 16'hffff;
            nxt_s.uidrx = 64'h0;
          end
        end
      end
      rfcd_pkg::RFCD_ST_ACC: begin
        // Access held until the addressed unit acknowledges
        if (i_ack) begin
          nxt_s.acc.req = 1'b0;
          if (s_ff.acc.wr) begin
            nxt_s.tbuf = {`RFCD_RSP_OK, 72'h0};
            nxt_s.tlen = 4'd1;
            nxt_s.st = (s_ff.tgt == 2'd0) ? rfcd_pkg::RFCD_ST_EOFW :
              rfcd_pkg::RFCD_ST_SEND;
          end else begin
            nxt_s.tbuf = {`RFCD_RSP_OK, i_rdata[7:0], i_rdata[15:8], 56'h0};
            nxt_s.tlen = 4'd3;
            nxt_s.tmore = (s_ff.cmd == `RFCD_CMD_RD_MULTI) && (s_ff.nblk != 8'h00);
            nxt_s.st = rfcd_pkg::RFCD_ST_SEND;
          end
        end
      end
      rfcd_pkg::RFCD_ST_EOFW: begin
        if (i_rx.valid && i_rx.eof) begin
          nxt_s.st = rfcd_pkg::RFCD_ST_SEND;
        end
      end
      rfcd_pkg::RFCD_ST_SEND: begin
        if (i_tx_ready) begin
          nxt_s.tx.valid = 1'b1;
          nxt_s.tx.data = tx_byte;
          nxt_s.crc = tx_crc; // Reply CRC runs over every byte sent
          nxt_s.tbuf = {s_ff.tbuf[71:0], 8'h00};
          nxt_s.tcnt = s_ff.tcnt + 4'd1;
          if (s_ff.tcnt + 4'd1 == s_ff.tlen) begin
            nxt_s.tcnt = 4'd0;
            if (s_ff.tmore) begin
              // Next consecutive block word, no flags byte
              nxt_s.nblk = s_ff.nblk - 8'h01;
              nxt_s.acc.addr = {8'h00, s_ff.acc.addr[7:0] + 8'h01};
              nxt_s.acc.req = 1'b1;
              nxt_s.st = rfcd_pkg::RFCD_ST_WAIT;
            end else begin
              nxt_s.st = rfcd_pkg::RFCD_ST_CRC;
            end
          end
        end
      end
      rfcd_pkg::RFCD_ST_WAIT: begin
        if (i_ack) begin
          nxt_s.acc.req = 1'b0;
          nxt_s.tbuf = {i_rdata[7:0], i_rdata[15:8], 64'h0};
          nxt_s.tlen = 4'd2;
          nxt_s.tcnt = 4'd0;
          nxt_s.tmore = (s_ff.nblk != 8'h00);
          nxt_s.st = rfcd_pkg::RFCD_ST_SEND;
        end
      end
      rfcd_pkg::RFCD_ST_CRC: begin
        // Complemented CRC sent low byte first
        if (i_tx_ready) begin
          nxt_s.tx.valid = 1'b1;
          nxt_s.tx.data = (s_ff.tcnt == 4'd0) ? ~tx_crc_final(s_ff) : ~s_ff.crc[15:8];
          nxt_s.tcnt = s_ff.tcnt + 4'd1;
          if (s_ff.tcnt == 4'd1) begin
            nxt_s.tx.last = 1'b1;
            nxt_s.tcnt = 4'd0;
            nxt_s.st = rfcd_pkg::RFCD_ST_IDLE;
          end
        end
      end
      default: nxt_s.st = rfcd_pkg::RFCD_ST_IDLE;
    endcase
  end

  // Low byte of the reply CRC
  function automatic logic [7:0] tx_crc_final(input rfcd_s_t s);
    return s.crc[7:0];
  endfunction : tx_crc_final

  // Registered state, frozen while the clock enable is low
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      s_ff <= '0;
      s_ff.st <= rfcd_pkg::RFCD_ST_IDLE;
      s_ff.tag <= rfcd_pkg::RFCD_READY;
    end else if (i_ce) begin
      s_ff <= nxt_s;
    end
  end

  // Access ports steered by target, unit picked by address byte
  always_comb begin
    o_eep = s_ff.acc;
    o_regf = s_ff.acc;
    o_idev = s_ff.acc;
    o_spi = s_ff.acc;
    o_eep.req = s_ff.acc.req && (s_ff.tgt == 2'd0);
    o_regf.req = s_ff.acc.req && (s_ff.tgt == 2'd1);
    o_idev.req = s_ff.acc.req && (s_ff.tgt == 2'd2);
    o_spi.req = s_ff.acc.req && (s_ff.tgt == 2'd3);
  end
  assign o_idev_unit = s_ff.acc.addr[7:0];
  assign o_tx = s_ff.tx;
  assign o_tag_state = s_ff.tag;
  assign o_busy = (s_ff.st != rfcd_pkg::RFCD_ST_IDLE);

  a_quiet_silent: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (s_ff.st == rfcd_pkg::RFCD_ST_RECV && nxt_s.tag == rfcd_pkg::RFCD_QUIET &&
     s_ff.tag != rfcd_pkg::RFCD_QUIET && i_ce) |=> !o_busy)
    else $error("stay quiet started a reply");
  a_write_waits: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (s_ff.st == rfcd_pkg::RFCD_ST_EOFW && !(i_rx.valid && i_rx.eof)) |=> !o_tx.valid)
    else $error("block write replied before end of frame");
  a_reset_ready: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (s_ff.st == rfcd_pkg::RFCD_ST_SEND && $past(s_ff.cmd) == `RFCD_CMD_RST_READY &&
     $past(s_ff.st) == rfcd_pkg::RFCD_ST_RECV) |-> o_tag_state == rfcd_pkg::RFCD_READY)
    else $error("reset to ready missed ready state");
  a_one_target: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $onehot0({o_eep.req, o_regf.req, o_idev.req, o_spi.req}))
    else $error("more than one access target");
  a_select_match: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && s_ff.st == rfcd_pkg::RFCD_ST_RECV && i_rx.valid && i_rx.eof &&
     s_ff.cmd == `RFCD_CMD_SELECT && s_ff.uidrx != i_uid) |=> $stable(o_tag_state) && !o_busy)
    else $error("foreign select changed state");
  a_bad_crc: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && s_ff.st == rfcd_pkg::RFCD_ST_RECV && i_rx.valid && i_rx.eof &&
     s_ff.crc != `RFCD_CRC_RESIDUE) |=> !o_busy && $stable(o_tag_state))
    else $error("corrupt frame was acted on");
  a_ack_drops: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_ce && o_eep.req && i_ack) |=> !o_eep.req)
    else $error("access request held after ack");
  a_last_ends: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (o_tx.valid && o_tx.last) |-> !o_busy)
    else $error("frame end without return to idle");
  c_inventory: cover property (@(posedge i_clk_sys) s_ff.tlen == 4'd10 && o_tx.last);
  c_multi: cover property (@(posedge i_clk_sys) s_ff.st == rfcd_pkg::RFCD_ST_WAIT);
  c_eofw: cover property (@(posedge i_clk_sys) s_ff.st == rfcd_pkg::RFCD_ST_EOFW);
endmodule : rfcd_decoder

//--- tb/rfcd_reader.sv
// Reader model: sends request frames and collects reply bytes
`timescale 1ns/1ps
`include "rfcd_regs.svh"
module rfcd_reader (
  input wire logic i_clk_sys,
  output rfcd_pkg::rfcd_rx_t o_rx,
  output logic o_tx_ready,
  input wire rfcd_pkg::rfcd_tx_t i_tx
);
  logic [7:0] rsp[$];
  logic got_last;
  logic slow;
  initial begin
    o_rx = '0;
    o_tx_ready = 1'b1;
    slow = 1'b0;
    got_last = 1'b0;
  end
  // Request CRC, complemented, sent low byte first
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = `RFCD_CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ `RFCD_CRC_POLY) : (c >> 1);
      end
    end
    return ~c;
  endfunction : crc16
  // One receive event; released data shows the inverse of the last byte
  task automatic put(input logic s, input logic e, input logic v, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_rx = '{valid: v, sof: s, eof: e, data: d};
    @(negedge i_clk_sys);
    o_rx = '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~d};
  endtask : put
  // Whole frame: start, bytes, CRC, end; bad corrupts the CRC
  task automatic send_frame(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    rsp.delete();
    got_last = 1'b0;
    c = crc16(q) ^ {15'h0000, bad};
    put(1'b1, 1'b0, 1'b1, 8'h00); // Start and end events carry valid
    foreach (q[i]) put(1'b0, 1'b0, 1'b1, q[i]);
    put(1'b0, 1'b0, 1'b1, c[7:0]);
    put(1'b0, 1'b0, 1'b1, c[15:8]);
    put(1'b0, 1'b1, 1'b1, 8'h00);
  endtask : send_frame
  // Separate end of frame that releases a deferred reply
  task automatic send_eof();
    put(1'b0, 1'b1, 1'b1, 8'h00);
  endtask : send_eof
  // Ready stalls every other cycle in slow mode
  always @(negedge i_clk_sys) o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
  // Collect reply bytes
  always @(posedge i_clk_sys) begin
    if (i_tx.valid === 1'b1) begin
      rsp.push_back(i_tx.data);
      if (i_tx.last === 1'b1) got_last = 1'b1;
    end
  end
endmodule : rfcd_reader

//--- tb/tb_top.sv
// Self-checking bench of the command decoder
`timescale 1ns/1ps
`include "rfcd_regs.svh"
module tb_top;
  typedef logic [7:0] rfcd_bytes_t[$];
  localparam logic [63:0] OWN_UID = 64'h0123_4567_89ab_cdef; // Arbitrary identifier
  logic i_clk_sys;
  logic i_reset;
  logic i_ack;
  logic [15:0] i_rdata;
  logic tx_ready;
  rfcd_pkg::rfcd_rx_t rx;
  rfcd_pkg::rfcd_tx_t tx;
  rfcd_pkg::rfcd_acc_t o_eep;
  rfcd_pkg::rfcd_acc_t o_regf;
  rfcd_pkg::rfcd_acc_t o_idev;
  rfcd_pkg::rfcd_acc_t o_spi;
  rfcd_pkg::rfcd_tag_t tag;
  logic [7:0] unit;
  logic [7:0] unit_seen;
  logic o_busy;
  logic [40:0] log_q[$];
  int fails;
  int n_tests;
  rfcd_decoder dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ce(1'b1), .i_uid(OWN_UID),
    .i_rx(rx), .o_tx(tx), .i_tx_ready(tx_ready), .o_eep(o_eep), .o_regf(o_regf),
    .o_idev(o_idev), .o_idev_unit(unit), .o_spi(o_spi), .i_ack(i_ack), .i_rdata(i_rdata),
    .o_tag_state(tag), .o_busy(o_busy));
  rfcd_reader reader (.i_clk_sys(i_clk_sys), .o_rx(rx), .o_tx_ready(tx_ready), .i_tx(tx));
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  // Memory side: acks two cycles late, read data tells target and address
  initial begin : mem_model
    rfcd_pkg::rfcd_acc_t a;
    logic [7:0] t;
    i_ack = 1'b0;
    i_rdata = 16'h0000;
    forever begin
      @(negedge i_clk_sys);
      a = o_eep.req ? o_eep : o_regf.req ? o_regf : o_idev.req ? o_idev : o_spi;
      t = o_eep.req ? 8'he1 : o_regf.req ? 8'h2b : o_idev.req ? 8'h3c : 8'h4d;
      if (a.req === 1'b1) begin
        unit_seen = unit;
        repeat (2) @(negedge i_clk_sys);
        log_q.push_back({a.wr, t, a.addr, a.wdata});
        i_rdata = {t, a.addr[7:0]};
        i_ack = 1'b1;
        @(negedge i_clk_sys);
        i_ack = 1'b0;
        i_rdata = ~i_rdata;
      end
    end
  end
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check
  task automatic complete_run();
    $display("Tests %0d, failures %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  // A used-up wait counts as a mismatch and ends the run
  task automatic time_out(input string msg);
    fails++;
    $display("ERROR %0t %s", $time, msg);
    complete_run();
  endtask : time_out
  function automatic rfcd_bytes_t uid_b(input logic [63:0] u);
    rfcd_bytes_t q;
    for (int i = 0; i < 8; i++) q.push_back(u[8*i+:8]);
    return q;
  endfunction : uid_b
  // Wait for the last reply byte, then compare the frame with its CRC
  task automatic expect_reply(input logic [7:0] e[$]);
    logic [15:0] c;
    c = reader.crc16(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    for (int i = 0; i < 600 && reader.got_last !== 1'b1; i++) @(negedge i_clk_sys);
    if (reader.got_last !== 1'b1) time_out("no reply");
    else check(reader.rsp == e, "reply bytes differ");
  endtask : expect_reply
  task automatic expect_silent();
    for (int i = 0; i < 300 && o_busy !== 1'b0; i++) @(negedge i_clk_sys);
    if (o_busy !== 1'b0) time_out("decoder stuck busy");
    repeat (20) @(negedge i_clk_sys);
    check(reader.rsp.size() == 0, "unexpected reply");
  endtask : expect_silent
  task automatic txn(input logic [7:0] f[$], input logic [7:0] e[$]);
    reader.send_frame(f, 1'b0);
    expect_reply(e);
  endtask : txn
  task automatic t_inventory();
    txn({8'h26, `RFCD_CMD_INVENTORY, 8'h00}, {8'h00, `RFCD_DSFID, uid_b(OWN_UID)});
    reader.send_frame({8'h26, `RFCD_CMD_INVENTORY, 8'h00}, 1'b1);
    expect_silent();
  endtask : t_inventory
  task automatic t_read_single();
    txn({8'h02, `RFCD_CMD_RD_SINGLE, 8'hff}, {8'h00, 8'hff, 8'he1});
    check(log_q[$][40:16] === {1'b0, 8'he1, 16'h00ff}, "eeprom read access");
  endtask : t_read_single
  task automatic t_write_single();
    reader.send_frame({8'h42, `RFCD_CMD_WR_SINGLE, 8'h10, 8'h34, 8'h12}, 1'b0);
    repeat (40) @(negedge i_clk_sys);
    check(reader.rsp.size() == 0, "reply before separate eof");
    check(log_q[$] === {1'b1, 8'he1, 16'h0010, 16'h1234}, "eeprom write access");
    reader.send_eof();
    expect_reply({`RFCD_RSP_OK});
    txn({8'h02, `RFCD_CMD_WR_SINGLE, 8'h10, 8'h34, 8'h12}, {`RFCD_RSP_ERR, 8'h03});
  endtask : t_write_single
  task automatic t_multi();
    reader.slow = 1'b1;
    txn({8'h02, `RFCD_CMD_RD_MULTI, 8'hfe, 8'h02},
      {8'h00, 8'hfe, 8'he1, 8'hff, 8'he1, 8'h00, 8'he1});
    reader.slow = 1'b0;
    check(log_q[$][31:16] === 16'h0000, "multi block wrap address");
  endtask : t_multi
  task automatic t_select();
    reader.send_frame({8'h22, `RFCD_CMD_SELECT, uid_b(~OWN_UID)}, 1'b0);
    expect_silent();
    check(tag === rfcd_pkg::RFCD_READY, "foreign select changed state");
    txn({8'h22, `RFCD_CMD_SELECT, uid_b(OWN_UID)}, {`RFCD_RSP_OK});
    check(tag === rfcd_pkg::RFCD_SELECTED, "not selected");
    txn({8'h22, `RFCD_CMD_RST_READY, uid_b(OWN_UID)}, {`RFCD_RSP_OK});
    check(tag === rfcd_pkg::RFCD_READY, "reset to ready");
  endtask : t_select
  task automatic t_quiet();
    reader.send_frame({8'h22, `RFCD_CMD_QUIET, uid_b(OWN_UID)}, 1'b0);
    expect_silent();
    check(tag === rfcd_pkg::RFCD_QUIET, "not quiet");
    reader.send_frame({8'h26, `RFCD_CMD_INVENTORY, 8'h00}, 1'b0);
    expect_silent();
  endtask : t_quiet
  task automatic t_custom();
    txn({8'h02, `RFCD_CMD_RD_REGF, `RFCD_MAKER_CODE, 8'h07}, {8'h00, 8'h07, 8'h2b});
    txn({8'h02, `RFCD_CMD_WR_REGF, `RFCD_MAKER_CODE, 8'h07, 8'hcd, 8'hab}, {8'h00});
    check(log_q[$] === {1'b1, 8'h2b, 16'h0007, 16'habcd}, "register file write");
    txn({8'h02, `RFCD_CMD_RD_IDEV, `RFCD_MAKER_CODE, 8'h33}, {8'h00, 8'h33, 8'h3c});
    check(unit_seen === 8'h33, "internal unit select");
    txn({8'h02, `RFCD_CMD_WR_IDEV, `RFCD_MAKER_CODE, 8'h44, 8'h78, 8'h56}, {8'h00});
    check(log_q[$] === {1'b1, 8'h3c, 16'h0044, 16'h5678}, "internal write");
    check(unit_seen === 8'h44, "internal unit select");
    txn({8'h02, `RFCD_CMD_RD_XMEM, `RFCD_MAKER_CODE, 8'h34, 8'h12}, {8'h00, 8'h34, 8'h4d});
    check(log_q[$][40:16] === {1'b0, 8'h4d, 16'h1234}, "external read");
  endtask : t_custom
  task automatic t_unknown();
    txn({8'h02, 8'h2b}, {`RFCD_RSP_ERR, `RFCD_ERR_UNSUPP});
  endtask : t_unknown
  // Main sequence
  initial begin
    fails = 0;
    n_tests = 0;
    unit_seen = 8'h00;
    i_reset = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_reset = 1'b0;
    check(tag === rfcd_pkg::RFCD_READY, "reset state");
    t_inventory();
    t_read_single();
    t_write_single();
    t_multi();
    t_custom();
    t_unknown();
    t_select();
    t_quiet();
    // Mid-run reset brings a quiet tag back to ready
    i_reset = 1'b1;
    @(negedge i_clk_sys);
    i_reset = 1'b0;
    check(tag === rfcd_pkg::RFCD_READY && o_busy === 1'b0, "mid-run reset state");
    txn({8'h26, `RFCD_CMD_INVENTORY, 8'h00}, {8'h00, `RFCD_DSFID, uid_b(OWN_UID)});
    complete_run();
  end
endmodule : tb_top
